// ===== verilog/sbpr_regs.sv
`timescale 1ns/1ps
module sbpr_regs #(
   parameter int LONG_RESET_CYCLES = sbpr_pkg::LONG_RESET_CYC
)
(
   input  wire logic                  clock,
   input  wire logic                  rstn,
   input  wire sbpr_pkg::sbpr_req_type req,
   output logic [7:0]                 rdata,
   input  wire sbpr_pkg::sbpr_arb_type arb,
   input  wire logic                  cable_power_sense,
   input  wire logic                  traffic_busy,
   output logic                       long_bus_reset_active,
   output logic                       root_holdoff,
   output logic [5:0]                 gap_setting,
   output logic [5:0]                 node_address_field,
   output logic                       node_address_valid,
   output logic                       root_flag
);
   import sbpr_pkg::*;

   logic [7:0]         rdata_q;
   logic               root_holdoff_q;
   logic               lbr_req_q;
   logic [5:0]         gap_q;
   logic [1:0]         br_count_q;
   logic [5:0]         node_q;
   logic               node_valid_q;
   logic               root_q;
   logic               cps_q;
   logic [2:0]         page_q;
   logic [3:0]         psel_q;
   logic               lbr_active_q;
   logic [14:0]        lbr_cnt_q;
   sbpr_lbr_state_type lbr_state_q;
   logic               wr_gap;

   // Decode a write to a given base address
   function automatic logic wr_hit(input sbpr_req_type r, input logic [3:0] a);
      wr_hit = r.wr && (r.addr == a);
   endfunction : wr_hit

   assign wr_gap = wr_hit(req, ADDR_GAP);

   // Root holdoff survives bus reset, only hardware reset or a gap register write with bit 7 low clears it
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         root_holdoff_q <= 1'b0;
      else if (wr_gap)
         root_holdoff_q <= req.wdata[POS_HOLDOFF];
   end

   // Request bit; a bus reset in the same cycle still clears it
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         lbr_req_q <= 1'b0;
      else if (arb.bus_reset || lbr_active_q)
         lbr_req_q <= 1'b0;
      else if (wr_gap && req.wdata[POS_LBR])
         lbr_req_q <= 1'b1;
   end

   // Long bus reset sequencer: waits for traffic to drain first
   // A bus reset while waiting drops the request, so no stale reset follows
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         lbr_state_q  <= LBR_IDLE;
         lbr_cnt_q    <= 15'h0000;
         lbr_active_q <= 1'b0;
      end
      else
      begin
         unique case (lbr_state_q)
            LBR_IDLE:
               if (lbr_req_q)
                  lbr_state_q <= LBR_WAIT;
            LBR_WAIT:
               if (!lbr_req_q)
                  lbr_state_q <= LBR_IDLE;
               else if (!traffic_busy)
               begin
                  lbr_state_q  <= LBR_BUSY;
                  lbr_active_q <= 1'b1;
                  lbr_cnt_q    <= 15'(LONG_RESET_CYCLES - 1);
               end
            LBR_BUSY:
               if (lbr_cnt_q == 15'h0000)
               begin
                  lbr_state_q  <= LBR_IDLE;
                  lbr_active_q <= 1'b0;
               end
               else
                  lbr_cnt_q <= lbr_cnt_q - 15'h0001;
            default:
               lbr_state_q <= LBR_IDLE;
         endcase
      end
   end

   // Gap setting; two bus resets without an update restore 3Fh
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         gap_q      <= GAP_RESET;
         br_count_q <= 2'h0;
      end
      else if (wr_gap)
      begin
         gap_q      <= req.wdata[5:0];
         br_count_q <= 2'h0;
      end
      else if (arb.gap_pkt)
      begin
         gap_q      <= arb.gap_pkt_value;
         br_count_q <= 2'h0;
      end
      else if (arb.bus_reset)
      begin
         if (br_count_q + 2'h1 >= BR_COUNT_MAX)
         begin
            gap_q      <= GAP_RESET;
            br_count_q <= 2'h0;
         end
         else
            br_count_q <= br_count_q + 2'h1;
      end
   end

   // Node address and root flag from identification phases
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         node_q       <= 6'h00;
         node_valid_q <= 1'b0;
         root_q       <= 1'b0;
      end
      else if (arb.bus_reset)
      begin
         node_valid_q <= 1'b0;
         root_q       <= 1'b0;
      end
      else
      begin
         if (arb.tree_root)
            root_q <= 1'b1;
         if (arb.self_id_done)
         begin
            node_q       <= arb.self_id_addr;
            node_valid_q <= 1'b1;
         end
      end
   end

   // Cable power mirror, registered so the read path is clean
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         cps_q <= 1'b0;
      else
         cps_q <= cable_power_sense;
   end

   // Page and port choice
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         page_q <= PAGE_RESET;
         psel_q <= PSEL_RESET;
      end
      else if (wr_hit(req, ADDR_PAGE))
      begin
         page_q <= req.wdata[7:5];
         psel_q <= req.wdata[3:0];
      end
   end

   // Read data one cycle after the strobe; all else reads zero
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rdata_q <= 8'h00;
      else if (req.rd)
      begin
         unique case (req.addr)
            ADDR_NODE:  rdata_q <= {node_q, root_q, cps_q};
            ADDR_GAP:   rdata_q <= {root_holdoff_q, lbr_req_q, gap_q};
            ADDR_EXT:   rdata_q <= {EXT_VALUE, 1'b0, PORT_COUNT};
            ADDR_SPEED: rdata_q <= {SPEED_VALUE, 1'b0, DELAY_VALUE};
            ADDR_LINK:  rdata_q <= {2'b00, JITTER_VALUE, 3'b000};
            ADDR_PAGE:  rdata_q <= {page_q, 1'b0, psel_q};
            default:    rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   // Outputs straight from flip-flops
   assign rdata                 = rdata_q;
   assign long_bus_reset_active = lbr_active_q;
   assign root_holdoff          = root_holdoff_q;
   assign gap_setting           = gap_q;
   assign node_address_field    = node_q;
   assign node_address_valid    = node_valid_q;
   assign root_flag             = root_q;

endmodule : sbpr_regs

// ===== verilog/sbpr_pkg.sv
// Operation
// - Sixteen registers reachable over register port
// - Base 0-7 fixed, 8-15 follow page; code reads 8-15 as zero on every page
// - Page field in register seven picks page; code only stores it and reads it back
// - Base fields same on every page
// - Reserved registers and fields read zero
// - Pages two to six read reserved
// - Node address from self-ID, invalid until done
// - Root flag clears on reset, set by tree-ID
// - Cable power bit mirrors sense input
// - Root holdoff kept across bus resets
// - Long bus reset request starts long reset
// - Traffic in progress finishes before reset
// - Long reset request clears on any reset
// - Gap setting drives arbiter timing
// - Gap updated by write or config packet
// - Gap to 3Fh on reset or two resets
// - Extended indicator reads 111
// - Port count reads 0010
// - Speed 010, delay 0000
// - Jitter reads 000
package sbpr_pkg;

   localparam logic [3:0] ADDR_NODE   = 4'h0;
   localparam logic [3:0] ADDR_GAP    = 4'h1;
   localparam logic [3:0] ADDR_EXT    = 4'h2;
   localparam logic [3:0] ADDR_SPEED  = 4'h3;
   localparam logic [3:0] ADDR_LINK   = 4'h4;
   localparam logic [3:0] ADDR_INTR   = 4'h5;
   localparam logic [3:0] ADDR_RSVD6  = 4'h6;
   localparam logic [3:0] ADDR_PAGE   = 4'h7;

   // Field positions
   localparam int         POS_NODE_ADDR = 2;
   localparam int         POS_ROOT      = 1;
   localparam int         POS_CPS       = 0;
   localparam int         POS_HOLDOFF   = 7;
   localparam int         POS_LBR       = 6;
   localparam int         POS_PAGE      = 5;

   // Constant fields
   localparam logic [2:0] EXT_VALUE     = 3'h7;
   localparam logic [3:0] PORT_COUNT    = 4'h2;
   localparam logic [2:0] SPEED_VALUE   = 3'h2;
   localparam logic [3:0] DELAY_VALUE   = 4'h0;
   localparam logic [2:0] JITTER_VALUE  = 3'h0;

   // Reset values and bus reset count limit
   localparam logic [5:0] GAP_RESET     = 6'h3f;
   localparam logic [2:0] PAGE_RESET    = 3'h0;
   localparam logic [3:0] PSEL_RESET    = 4'h0;
   localparam logic [1:0] BR_COUNT_MAX  = 2'h2;

   // Long bus reset length: 166 us at 125 MHz
   localparam int         LONG_RESET_US = 166;
   localparam int         CLOCK_MHZ     = 125;
   localparam int         LONG_RESET_CYC = LONG_RESET_US * CLOCK_MHZ;

   typedef enum logic [1:0]
   {
      LBR_IDLE = 2'b00,
      LBR_WAIT = 2'b01,
      LBR_BUSY = 2'b10
   } sbpr_lbr_state_type;

   // Register port request
   typedef struct packed
   {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sbpr_req_type;

   // Bus reset, self-ID, tree-ID and gap packet results from the arbiter
   typedef struct packed
   {
      logic       bus_reset;
      logic       tree_root;
      logic       self_id_done;
      logic [5:0] self_id_addr;
      logic       gap_pkt;
      logic [5:0] gap_pkt_value;
   } sbpr_arb_type;

endpackage : sbpr_pkg

// ===== sim/sbpr_arb_model.sv
`timescale 1ns/1ps
// Arbiter side of the register bank: turns a bench command into result pulses
module sbpr_arb_model
(
   input  wire logic            clock,
   input  wire logic [2:0]      cmd,
   input  wire logic [5:0]      val,
   output sbpr_pkg::sbpr_arb_type arb
);
   import sbpr_pkg::*;
   // Registered decode of cmd, so a held command holds its flag high for as many cycles
   always_ff @(posedge clock)
   begin
      arb.bus_reset     <= (cmd == 3'h1);
      arb.tree_root     <= (cmd == 3'h2);
      arb.self_id_done  <= (cmd == 3'h3);
      arb.self_id_addr  <= val;
      arb.gap_pkt       <= (cmd == 3'h4);
      arb.gap_pkt_value <= val;
   end
endmodule : sbpr_arb_model

// ===== sim/sbpr_properties.sv
`timescale 1ns/1ps
module sbpr_regs_checker #(
   parameter int LONG_RESET_CYCLES = 10
)
(
   input wire logic                   clock,
   input wire logic                   rstn,
   input wire sbpr_pkg::sbpr_req_type req,
   input wire logic [7:0]             rdata,
   input wire sbpr_pkg::sbpr_arb_type arb,
   input wire logic                   traffic_busy,
   input wire logic                   long_bus_reset_active,
   input wire logic                   root_holdoff,
   input wire logic [5:0]             gap_setting,
   input wire logic [5:0]             node_address_field,
   input wire logic                   root_flag
);
   import sbpr_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   int unsigned run_q;
   // Counts the running long reset; too long for a repetition operator
   always_ff @(posedge clock or negedge rstn)
      if (!rstn)
         run_q <= 0;
      else
         run_q <= long_bus_reset_active ? run_q + 1 : 0;
   a_idle_read_zero:
      assert property (!req.rd |=> rdata == 8'h00) else $error("rdata not zero");
   a_upper_read_zero:
      assert property (req.rd && req.addr[3] |=> rdata == 8'h00) else $error("paged not zero");
   a_port_info_const:
      assert property (req.rd && req.addr == ADDR_EXT |=> rdata == 8'he2) else $error("reg2 bad");
   a_speed_info_const:
      assert property (req.rd && req.addr == ADDR_SPEED |=> rdata == 8'h40) else $error("reg3 bad");
   a_node_read_match:
      assert property (req.rd && req.addr == ADDR_NODE |=> rdata[7:2] == $past(node_address_field)
         && rdata[1] == $past(root_flag)) else $error("reg0 bad");
   a_gap_write_take:
      assert property (req.wr && req.addr == ADDR_GAP && !arb.bus_reset
         |=> gap_setting == $past(req.wdata[5:0])) else $error("gap write lost");
   a_gap_pkt_take:
      assert property (arb.gap_pkt && !req.wr |=> gap_setting == $past(arb.gap_pkt_value))
         else $error("gap packet lost");
   a_root_bus_clear:
      assert property (arb.bus_reset && !arb.tree_root |=> !root_flag) else $error("root kept");
   a_holdoff_survives:
      assert property (arb.bus_reset && !req.wr |=> $stable(root_holdoff)) else $error("holdoff lost");
   a_reset_waits_idle:
      assert property ($rose(long_bus_reset_active) |-> !$past(traffic_busy)) else $error("cut traffic");
   a_long_reset_len:
      assert property ($fell(long_bus_reset_active) |-> run_q == LONG_RESET_CYCLES)
         else $error("long reset length");
endmodule : sbpr_regs_checker
bind sbpr_regs sbpr_regs_checker #(.LONG_RESET_CYCLES(LONG_RESET_CYCLES)) u_chk (
   .clock(clock), .rstn(rstn), .req(req), .rdata(rdata), .arb(arb), .traffic_busy(traffic_busy),
   .long_bus_reset_active(long_bus_reset_active), .root_holdoff(root_holdoff),
   .gap_setting(gap_setting), .node_address_field(node_address_field), .root_flag(root_flag)
);

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import sbpr_pkg::*;
   logic clock, rstn, cps_in, busy, lbra, root, cable_power_state, hold, ho, rf, nav;
   logic [2:0] cmd;
   logic [5:0] val, node, gap, gs, naf;
   logic [7:0] rdata, pg, r;
   sbpr_req_type req;
   sbpr_arb_type arb;
   int fails, tests_run, cycles, i, n;
   sbpr_arb_model u_arb (.clock(clock), .cmd(cmd), .val(val), .arb(arb));
   sbpr_regs #(.LONG_RESET_CYCLES(10)) u_dut (.clock(clock), .rstn(rstn), .req(req),
      .rdata(rdata), .arb(arb), .cable_power_sense(cps_in), .traffic_busy(busy),
      .long_bus_reset_active(lbra), .root_holdoff(ho), .gap_setting(gs),
      .node_address_field(naf), .node_address_valid(nav),
      .root_flag(rf));
   function automatic logic [7:0] lf(input logic [7:0] s);
      lf = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lf
   // Bench model of the readable bank
   function automatic logic [7:0] ex(input int a);
      case (a)
         0: ex = {node, root, cable_power_state};
         1: ex = {hold, 1'b0, gap};
         2: ex = 8'he2;
         3: ex = 8'h40;
         7: ex = pg;
         default: ex = 8'h00;
      endcase
   endfunction : ex
   task automatic test_done;
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("Error %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   // An idle cycle after each strobe keeps every driver change in its own step
   task automatic wr(input int a, input logic [7:0] d);
      req <= '{addr: a[3:0], wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      req <= '0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input int a, input logic [7:0] e);
      req <= '{addr: a[3:0], wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      req <= '0;
      #1 chk(rdata, e);
      @(posedge clock);
   endtask : rd
   task automatic pulse(input logic [2:0] c, input logic [5:0] v);
      cmd <= c;
      val <= v;
      @(posedge clock);
      cmd <= 3'h0;
      repeat (3) @(posedge clock);
   endtask : pulse
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fails++;
         test_done();
      end
   end
   initial
   begin
      rstn = 0; req = '0; cmd = 0; val = 0; cps_in = 1; busy = 0; r = 8'h3a;
      node = 0; root = 0; cable_power_state = 1; hold = 0; gap = 6'h3f; pg = 8'h00;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      for (i = 0; i < 16; i++) rd(i, ex(i));
      repeat (4)
      begin
         r = lf(r);
         hold = r[7];
         gap = r[5:0];
         wr(1, r & 8'hbf);
         wr(2, ~r);
         rd(1, ex(1));
         rd(2, ex(2));
         chk({ho, 1'b0, gs}, {hold, 1'b0, gap});
      end
      for (i = 0; i < 8; i++)
      begin
         pg = {i[2:0], 1'b0, r[3:0]};
         wr(7, {i[2:0], 1'b1, r[3:0]});
         rd(7, pg);
         rd(3, ex(3));
         rd(8 + i, 8'h00);
      end
      hold = 1;
      gap = 6'h15;
      wr(1, 8'h95);
      pulse(3'h1, 6'h00);
      rd(1, ex(1));
      chk({7'h0, ho}, 8'h01);
      pulse(3'h1, 6'h00);
      gap = 6'h3f;
      rd(1, ex(1));
      pulse(3'h2, 6'h00);
      root = 1;
      rd(0, ex(0));
      chk({7'h0, rf}, 8'h01);
      pulse(3'h1, 6'h00);
      root = 0;
      chk({6'h00, nav, rf}, 8'h00);
      r = lf(r);
      node = r[5:0];
      pulse(3'h3, node);
      rd(0, ex(0));
      chk({1'b0, nav, naf}, {2'b01, node});
      cps_in <= 0;
      cable_power_state = 0;
      repeat (2) @(posedge clock);
      rd(0, ex(0));
      gap = 6'h2a;
      pulse(3'h4, gap);
      rd(1, ex(1));
      chk({2'b00, gs}, {2'b00, gap});
      // A bus reset while the request waits on traffic must drop it
      busy <= 1;
      wr(1, {hold, 1'b1, gap});
      rd(1, {hold, 1'b1, gap});
      pulse(3'h1, 6'h00);
      busy <= 0;
      rd(1, ex(1));
      chk({6'h00, nav, lbra}, 8'h00);
      busy <= 1;
      wr(1, {hold, 1'b1, gap});
      repeat (20) @(posedge clock);
      #1 chk({7'h0, lbra}, 8'h00);
      busy <= 0;
      n = 0;
      while (lbra !== 1'b1 && n < 50)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      n = 0;
      while (lbra === 1'b1 && n < 50)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(n[7:0], 8'h0a);
      @(posedge clock);
      rd(1, ex(1));
      test_done();
   end
endmodule : tb_top
